// ### rtl/hcs_device.sv
// device end: serial shifter on the link clock, acquisition control on ref_clk_i
`timescale 1ns/10ps
module hcs_device (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  hcs_link_if.device link,
  input wire logic acq_done_i,
  input wire logic [hcs_pkg::CODE_W-1:0] acq_code_i,
  output logic acq_start_o,
  output logic acq_all_o,
  output logic [5:0] acq_channel_o,
  output logic route_vin_o
);
  // ----------------------------------------------------------------------
  // serial side, clocked by the link clock and the frame select edge
  // ----------------------------------------------------------------------
  logic start_tgl;
  logic seen_tgl;
  logic rb_pend;
  logic rb_frame;
  logic test_st;
  logic wr_tgl;
  logic rb_on_tgl;
  logic rb_off_tgl;
  logic dout_q;
  logic frame_new;
  logic shifting;
  logic [4:0] cnt;
  logic [4:0] need;
  logic [9:0] sh;
  logic [9:0] word;
  logic [3:0] idx;
  logic [9:0] next_word;
  logic [hcs_pkg::CODE_W-1:0] rb_word;

  assign frame_new = start_tgl != seen_tgl;
  assign need = rb_frame ? hcs_pkg::RB_BITS : (test_st ? hcs_pkg::TEST_BITS : hcs_pkg::WR_BITS);
  assign shifting = frame_new | (cnt < need);
  assign next_word = {sh[8:0], link.din};

  // frame fall is only honoured between words, so a stray fall mid-word is lost
  always_ff @(negedge link.sync_n or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_tgl <= 1'b0;
    else if (!shifting)
      start_tgl <= ~start_tgl;
  end

  // bit counter, input shifter and word decode on falling serial clock
  always_ff @(negedge link.sclk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seen_tgl <= 1'b0;
      cnt <= hcs_pkg::TEST_BITS;
      sh <= 10'h000;
      word <= 10'h000;
      rb_pend <= 1'b0;
      rb_frame <= 1'b0;
      test_st <= 1'b0;
      wr_tgl <= 1'b0;
      rb_off_tgl <= 1'b0;
    end
    else if (frame_new)
    begin
      seen_tgl <= start_tgl;
      cnt <= 5'h01;
      rb_frame <= rb_pend;
      rb_pend <= 1'b0;
      if (!rb_pend)
        sh <= next_word;
    end
    else if (cnt < need)
    begin
      cnt <= cnt + 5'h01;
      if (!rb_frame)
        sh <= next_word; // input ignored in a readback frame
      if (cnt + 5'h01 == need)
      begin
        if (rb_frame)
          rb_off_tgl <= ~rb_off_tgl; // release on 14th fall
        else if (test_st)
          test_st <= 1'b0; // any 24-clock word leaves test
        else if (next_word[9:8] == hcs_pkg::MODE_TEST)
        begin
          test_st <= 1'b1;
          cnt <= hcs_pkg::TEST_BITS; // word complete, so the next frame fall is honoured
        end
        else
        begin
          word <= next_word;
          wr_tgl <= ~wr_tgl;
          rb_pend <= next_word[9];
        end
      end
    end
  end

  // readback shifter on rising serial clock
  always_ff @(posedge link.sclk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rb_on_tgl <= 1'b0;
      dout_q <= 1'b0;
      idx <= 4'h0;
    end
    else if (frame_new && rb_pend)
    begin
      rb_on_tgl <= ~rb_on_tgl; // drive from first rise
      dout_q <= rb_word[hcs_pkg::CODE_W-1];
      idx <= 4'(hcs_pkg::CODE_W - 2);
    end
    else if (link.dout_oe)
    begin
      dout_q <= rb_word[idx];
      if (idx != 4'h0)
        idx <= idx - 4'h1;
    end
  end

  // no readback drive while the parallel port is selected
  assign link.dout = dout_q;
  assign link.dout_oe = (rb_on_tgl ^ rb_off_tgl) & link.interface_select;

  // ----------------------------------------------------------------------
  // pin synchronisers into the reference clock domain
  // ----------------------------------------------------------------------
  localparam int IN_W = 12;
  localparam logic [IN_W-1:0] IN_RST = 12'hF00;
  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] s1;
  logic [IN_W-1:0] s2;
  logic [IN_W-1:0] s3;
  logic [IN_W-1:0] filt;
  logic [IN_W-1:0] prev;
  logic f_hold;
  logic f_wr_n;
  logic f_cs_n;
  logic f_isel;
  logic f_offs;
  logic f_cal;
  logic [4:0] f_ch;
  logic f_wtgl;
  logic p_hold;
  logic p_wr_n;
  logic p_cs_n;
  logic p_isel;
  logic p_offs;
  logic p_cal;
  logic [4:0] p_ch;
  logic p_wtgl;

  assign in_raw = {link.hold_release, link.wr_n, link.sync_n, link.interface_select,
                   link.par_offset_sel, link.par_cal, link.par_channel, wr_tgl};
  assign {f_hold, f_wr_n, f_cs_n, f_isel, f_offs, f_cal, f_ch, f_wtgl} = filt;
  assign {p_hold, p_wr_n, p_cs_n, p_isel, p_offs, p_cal, p_ch, p_wtgl} = prev;

  // a bit changes once the second and third stages agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= IN_RST;
      s2 <= IN_RST;
      s3 <= IN_RST;
      filt <= IN_RST;
      prev <= IN_RST;
    end
    else
    begin
      s1 <= in_raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
      prev <= filt;
    end
  end

  // ----------------------------------------------------------------------
  // address events and hold-release pulse classification
  // ----------------------------------------------------------------------
  logic ser_evt;
  logic par_evt;
  logic addr_evt;
  logic evt_acq;
  logic evt_cal;
  logic evt_offs;
  logic [4:0] evt_ch;
  logic hold_rise;
  logic soft_rst;
  logic [3:0] low_cnt;

  // the serial word is stable here: the next one needs ten more clocks
  assign ser_evt = (f_wtgl != p_wtgl) & f_isel;
  assign par_evt = ~f_isel & ~f_cs_n & f_wr_n & ~p_wr_n;
  assign addr_evt = ser_evt | par_evt;
  assign evt_acq = par_evt | (word[9:8] != hcs_pkg::MODE_RB);
  assign evt_cal = par_evt ? f_cal : word[hcs_pkg::POS_CAL];
  assign evt_offs = par_evt ? f_offs : word[hcs_pkg::POS_OFFS];
  assign evt_ch = par_evt ? f_ch : word[hcs_pkg::CH_W-1:0];
  assign soft_rst = f_hold & ~p_hold & (low_cnt >= hcs_pkg::RST_MIN_CYC)
                    & (low_cnt <= hcs_pkg::RST_MAX_CYC);
  // shorter lows are glitches and start nothing
  assign hold_rise = f_hold & ~p_hold & (low_cnt > hcs_pkg::RST_MAX_CYC);

  // saturating length of the current low on the hold-release input
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      low_cnt <= 4'h0;
    else if (f_hold)
      low_cnt <= 4'h0;
    else if (low_cnt != 4'hF)
      low_cnt <= low_cnt + 4'h1;
  end

  // ----------------------------------------------------------------------
  // acquisition sequencer
  // ----------------------------------------------------------------------
  hcs_pkg::hcs_acq_t state;
  logic [5:0] tgt_ch;
  logic tgt_all;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= hcs_pkg::HCS_IDLE;
    else if (soft_rst)
      state <= hcs_pkg::HCS_IDLE;
    else
    begin
      unique case (state)
        hcs_pkg::HCS_IDLE, hcs_pkg::HCS_WAIT_HOLD:
          if (addr_evt && evt_acq)
            state <= f_hold ? hcs_pkg::HCS_ACQ : hcs_pkg::HCS_WAIT_HOLD;
          else if (state == hcs_pkg::HCS_WAIT_HOLD && hold_rise)
            state <= hcs_pkg::HCS_ACQ;
        hcs_pkg::HCS_ACQ:
          if (acq_done_i)
            state <= hcs_pkg::HCS_IDLE;
      endcase
    end
  end

  // addresses arriving mid-acquisition are dropped
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tgt_ch <= 6'h00;
      tgt_all <= 1'b0;
    end
    else if (soft_rst)
    begin
      tgt_ch <= 6'h00;
      tgt_all <= 1'b0;
    end
    else if (addr_evt && state != hcs_pkg::HCS_ACQ)
    begin
      tgt_ch <= evt_offs ? hcs_pkg::OFFSET_CH : {1'b0, evt_ch};
      tgt_all <= evt_cal & evt_acq;
    end
  end

  // stored codes of the 32 channels and the offset channel
  logic [hcs_pkg::CODE_W-1:0] code_mem [0:hcs_pkg::NUM_CH];

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i <= hcs_pkg::NUM_CH; i++)
        code_mem[i] <= '0;
    end
    else if (soft_rst)
    begin
      for (int i = 0; i <= hcs_pkg::NUM_CH; i++)
        code_mem[i] <= '0;
    end
    else if (state == hcs_pkg::HCS_ACQ && acq_done_i)
    begin
      if (tgt_all)
      begin
        for (int i = 0; i < hcs_pkg::NUM_CH; i++)
          code_mem[i] <= acq_code_i;
      end
      else
        code_mem[tgt_ch] <= acq_code_i;
    end
  end

  // readback word held steady for the serial side between frames
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rb_word <= '0;
    else
      rb_word <= code_mem[tgt_ch];
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic busy_q;

  // input stays on the buffer while waiting and acquiring
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_q <= 1'b1;
      route_vin_o <= 1'b0;
      acq_start_o <= 1'b0;
    end
    else
    begin
      busy_q <= state != hcs_pkg::HCS_ACQ;
      route_vin_o <= state != hcs_pkg::HCS_IDLE;
      acq_start_o <= state == hcs_pkg::HCS_ACQ;
    end
  end

  assign link.busy_n = busy_q;
  assign acq_channel_o = tgt_ch;
  assign acq_all_o = tgt_all;
endmodule // hcs_device

// ### rtl/hcs_host.sv
// host end: drives frames, strobes and reset pulses toward the device
`timescale 1ns/10ps
module hcs_host #(
  parameter int HALF_CYC = 8,
  parameter int STROBE_CYC = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  hcs_link_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_mode_i,
  input wire logic cmd_cal_i,
  input wire logic cmd_offset_i,
  input wire logic [4:0] cmd_channel_i,
  input wire logic par_sel_i,
  input wire logic hold_release_i,
  input wire logic reset_pulse_i,
  output logic busy_o,
  output logic rb_valid_o,
  output logic [hcs_pkg::CODE_W-1:0] rb_data_o
);
  // ----------------------------------------------------------------------
  // incoming pins, three stages, change once stages two and three agree
  // ----------------------------------------------------------------------
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] filt;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      filt <= 2'h3;
    end
    else
    begin
      s1 <= {link.busy_n, link.dout_line};
      s2 <= s1;
      s3 <= s2;
      filt <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    end
  end

  assign busy_o = ~filt[1];

  // ----------------------------------------------------------------------
  // frame and strobe sequencer
  // ----------------------------------------------------------------------
  hcs_pkg::hcs_host_t state;
  logic [23:0] sh;
  logic [4:0] nbits;
  logic [4:0] bit_cnt;
  logic [7:0] div;
  logic [11:0] wait_cnt;
  logic rd_frame;
  logic gap_frame;
  logic [1:0] mode_q;
  logic [hcs_pkg::CODE_W-1:0] rbsh;
  logic sclk_q;
  logic sync_q;
  logic din_q;
  logic isel_q;
  logic hold_q;
  logic wr_q;

  assign cmd_ready_o = state == hcs_pkg::HCS_H_IDLE;

  // sclk idles low; din moves on the rise so it stands still at the device's sampling fall
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= hcs_pkg::HCS_H_IDLE;
      sh <= 24'h000000;
      nbits <= hcs_pkg::WR_BITS;
      bit_cnt <= 5'h00;
      div <= 8'h00;
      wait_cnt <= 12'h000;
      rd_frame <= 1'b0;
      gap_frame <= 1'b0;
      mode_q <= hcs_pkg::MODE_HOLD;
      rbsh <= '0;
      rb_data_o <= '0;
      rb_valid_o <= 1'b0;
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
      din_q <= 1'b0;
      isel_q <= 1'b1;
      hold_q <= 1'b1;
      wr_q <= 1'b1;
      link.par_channel <= 5'h00;
      link.par_offset_sel <= 1'b0;
      link.par_cal <= 1'b0;
    end
    else
    begin
      rb_valid_o <= 1'b0;
      unique case (state)
        hcs_pkg::HCS_H_IDLE:
        begin
          hold_q <= hold_release_i;
          if (reset_pulse_i)
          begin
            hold_q <= 1'b0;
            wait_cnt <= hcs_pkg::RST_PULSE_CYC;
            state <= hcs_pkg::HCS_H_PULSE;
          end
          else if (cmd_valid_i && par_sel_i)
          begin
            isel_q <= 1'b0;
            link.par_channel <= cmd_channel_i;
            link.par_offset_sel <= cmd_offset_i;
            link.par_cal <= cmd_cal_i;
            sync_q <= 1'b0;
            wr_q <= 1'b0;
            wait_cnt <= 12'(STROBE_CYC);
            state <= hcs_pkg::HCS_H_STROBE;
          end
          else if (cmd_valid_i)
          begin
            isel_q <= 1'b1;
            mode_q <= cmd_mode_i;
            // test bit forced low, word left-justified MSB first
            sh <= {cmd_mode_i, cmd_cal_i, cmd_offset_i, 1'b0, cmd_channel_i, 14'h0000};
            din_q <= cmd_mode_i[1];
            nbits <= hcs_pkg::WR_BITS;
            rd_frame <= 1'b0;
            bit_cnt <= 5'h00;
            div <= 8'(HALF_CYC - 1);
            sync_q <= 1'b0;
            state <= hcs_pkg::HCS_H_SHIFT;
          end
        end
        hcs_pkg::HCS_H_SHIFT:
          if (div != 8'h00)
            div <= div - 8'h01;
          else
          begin
            div <= 8'(HALF_CYC - 1);
            sclk_q <= ~sclk_q;
            // changing din on the fall would race the device's sample in the same time step
            if (!sclk_q)
              din_q <= sh[23];
            if (sclk_q)
            begin
              // falling edge: device samples din, readback bit is valid
              bit_cnt <= bit_cnt + 5'h01;
              sh <= {sh[22:0], 1'b0};
              rbsh <= {rbsh[hcs_pkg::CODE_W-2:0], filt[0]};
              if (bit_cnt + 5'h01 == nbits)
              begin
                sync_q <= 1'b1;
                state <= hcs_pkg::HCS_H_GAP;
                gap_frame <= 1'b0;
                wait_cnt <= 12'(HALF_CYC);
                if (rd_frame)
                begin
                  rb_data_o <= {rbsh[hcs_pkg::CODE_W-2:0], filt[0]};
                  rb_valid_o <= 1'b1;
                end
                else if (nbits == hcs_pkg::WR_BITS && mode_q == hcs_pkg::MODE_TEST)
                begin
                  gap_frame <= 1'b1;
                  sh <= 24'h000000;
                  nbits <= hcs_pkg::TEST_BITS;
                end
                else if (nbits == hcs_pkg::WR_BITS && mode_q[1])
                begin
                  gap_frame <= 1'b1;
                  rd_frame <= 1'b1;
                  nbits <= hcs_pkg::RB_BITS;
                  wait_cnt <= mode_q[0] ? hcs_pkg::RB_GAP_CYC : hcs_pkg::ACQ_WAIT_CYC;
                end
              end
            end
          end
        hcs_pkg::HCS_H_GAP:
          if (wait_cnt != 12'h000)
            wait_cnt <= wait_cnt - 12'h001;
          else if (gap_frame)
          begin
            sync_q <= 1'b0;
            din_q <= 1'b0;
            bit_cnt <= 5'h00;
            div <= 8'(HALF_CYC - 1);
            state <= hcs_pkg::HCS_H_SHIFT;
          end
          else
          begin
            sync_q <= 1'b1;
            state <= hcs_pkg::HCS_H_IDLE;
          end
        hcs_pkg::HCS_H_STROBE:
          if (wait_cnt != 12'h000)
            wait_cnt <= wait_cnt - 12'h001;
          else
          begin
            wr_q <= 1'b1; // rising edge latches the fields
            gap_frame <= 1'b0;
            wait_cnt <= 12'(STROBE_CYC);
            state <= hcs_pkg::HCS_H_GAP;
          end
        hcs_pkg::HCS_H_PULSE:
          if (wait_cnt != 12'h000)
            wait_cnt <= wait_cnt - 12'h001;
          else
          begin
            hold_q <= hold_release_i;
            state <= hcs_pkg::HCS_H_IDLE;
          end
        default:
          state <= hcs_pkg::HCS_H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.sync_n = sync_q;
  assign link.din = din_q;
  assign link.interface_select = isel_q;
  assign link.hold_release = hold_q;
  assign link.wr_n = wr_q;
endmodule // hcs_host

// ### rtl/hcs_link_if.sv
// link wires between the host controller and the hold channel device
`timescale 1ns/10ps
interface hcs_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  logic interface_select;
  logic hold_release;
  logic busy_n;
  logic wr_n;
  logic par_offset_sel;
  logic par_cal;
  logic [4:0] par_channel;

  // released readback line idles high through a pull-up
  assign dout_line = dout_oe ? dout : 1'b1;

  modport device (
    input sclk, sync_n, din, interface_select, hold_release, wr_n,
    input par_offset_sel, par_cal, par_channel,
    output dout, dout_oe, busy_n
  );
  modport host (
    output sclk, sync_n, din, interface_select, hold_release, wr_n,
    output par_offset_sel, par_cal, par_channel,
    input dout_line, busy_n
  );
endinterface

// ### rtl/hcs_pkg.sv
// constants, field layout and state types of the hold channel select port
// ----------------------------------------------------------------------
// Notes on behaviour
// - hold-release high: acquire as soon as addressed
// - hold-release low: route input, await rising edge
// - busy low from acquisition start until done
// - busy high switches buffer to converter output
// - first two bits select the operating mode
// - mode 01 enters test; 24-clock write leaves
// - host addresses with 10-bit word, MSB first
// - acquire-readback returns 14-bit code, ignores input
// - host waits full acquisition before readback frame
// - readback-only returns code without any acquisition
// - host waits 400 ns before readback frame
// - interface select high serial, low parallel
// - readback bit changes on rising serial clock
// - calibration bit makes all channels acquire
// - offset select addresses offset channel, ignores number
// - host always sends test bit as zero
// - five-bit binary channel number, top bit first
// - first frame fall clears counter; others ignored
// - after full word, clocks ignored until new frame
// - readback output driven from first rise to 14th fall
// - input sampled on falling edges; gated clocks fine
// - parallel fields latched on write strobe rising edge
// - 90-200 ns low pulse on hold-release resets
// ----------------------------------------------------------------------
package hcs_pkg;
  // ----------------------------------------------------------------------
  // word lengths and field layout
  // ----------------------------------------------------------------------
  localparam logic [4:0] WR_BITS = 5'h0A;
  localparam logic [4:0] RB_BITS = 5'h0E;
  localparam logic [4:0] TEST_BITS = 5'h18;
  localparam int CODE_W = 14;
  localparam int CH_W = 5;
  localparam int NUM_CH = 32;
  localparam logic [5:0] OFFSET_CH = 6'h20;
  localparam int POS_MODE = 8;
  localparam int POS_CAL = 7;
  localparam int POS_OFFS = 6;
  localparam int POS_TEST = 5;
  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_TEST = 2'h1;
  localparam logic [1:0] MODE_ACQ_RB = 2'h2;
  localparam logic [1:0] MODE_RB = 2'h3;
  // ----------------------------------------------------------------------
  // timing, figures in ns, counts in 20 ns cycles
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int RST_MIN_NS = 90;
  localparam int RST_MAX_NS = 200;
  localparam int RST_PULSE_NS = 150;
  localparam int ACQ_MAX_NS = 16000;
  localparam int RB_GAP_NS = 400;
  localparam logic [3:0] RST_MIN_CYC = 4'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RST_MAX_CYC = 4'(RST_MAX_NS / CLK_NS);
  localparam logic [11:0] RST_PULSE_CYC = 12'((RST_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] ACQ_WAIT_CYC = 12'((ACQ_MAX_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] RB_GAP_CYC = 12'((RB_GAP_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {HCS_IDLE = 2'b00, HCS_WAIT_HOLD = 2'b01, HCS_ACQ = 2'b11} hcs_acq_t;
  typedef enum logic [2:0] {
    HCS_H_IDLE = 3'b000,
    HCS_H_SHIFT = 3'b001,
    HCS_H_GAP = 3'b011,
    HCS_H_STROBE = 3'b010,
    HCS_H_PULSE = 3'b110
  } hcs_host_t;
endpackage

// ### verif/hcs_link_properties.sv
// checker of the link timing between host and device ends
`timescale 1ns/10ps
module hcs_link_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic busy_n,
  input wire logic hold_release,
  input wire logic acq_done_i,
  input wire logic acq_start_o,
  input wire logic route_vin_o
);
  logic [4:0] rb_cnt;
  // rises seen while readback drives, kept on the link clock
  always_ff @(posedge sclk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rb_cnt <= 5'h00;
    else
      rb_cnt <= dout_oe ? rb_cnt + 5'h01 : 5'h00;
  end
  // done seen while acquiring, then release of busy and buffer
  sequence s_done;
    acq_start_o && acq_done_i;
  endsequence
  sequence s_release;
    ##[1:3] busy_n && !route_vin_o;
  endsequence
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  a_oe_framed: assert property (@(posedge sclk) disable iff (!rst_n_i) dout_oe |-> !sync_n)
    else $error("readback drive outside a frame");
  a_rb_max: assert property (@(posedge sclk) disable iff (!rst_n_i) dout_oe |-> rb_cnt <= 5'h0C)
    else $error("readback drive too long");
  a_rb_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(dout_oe) |-> rb_cnt == 5'h0D)
    else $error("readback drive not fourteen rises");
  a_dout_rise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    dout_oe && $past(dout_oe) && $changed(dout) |-> $rose(sclk))
    else $error("readback bit changed off a rising edge");
  a_done_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) s_done |-> s_release)
    else $error("busy or buffer not released after done");
  a_busy_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(busy_n) |-> $past(acq_done_i) || $past(acq_done_i, 2) || $past(acq_done_i, 3))
    else $error("busy released without done");
  a_start_busy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(acq_start_o) |-> ##[0:3] !busy_n)
    else $error("busy not low after start");
  a_start_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(acq_start_o) |-> hold_release)
    else $error("acquisition began with hold low");
endmodule // hcs_link_properties

// ### verif/tb_top.sv
// bench joining host and device ends with a converter stand-in
`timescale 1ns/10ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic acq_done_i = 1'b0;
  logic [13:0] acq_code_i = 14'h0000;
  logic acq_start_o, acq_all_o, route_vin_o, cmd_ready_o, busy_o, rb_valid_o;
  logic [5:0] acq_channel_o;
  logic [13:0] rb_data_o;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_mode_i = 2'h0;
  logic cmd_cal_i = 1'h0;
  logic cmd_offset_i = 1'h0;
  logic [4:0] cmd_channel_i = 5'h00;
  logic par_sel_i = 1'h0;
  logic hold_release_i = 1'h1;
  logic reset_pulse_i = 1'h0;
  logic [13:0] mem [0:32];
  logic [13:0] cd;
  logic [5:0] tgt = 6'h00;
  logic all_t = 1'h0;
  logic [31:0] r;
  int err_count = 0;
  int checked = 0;
  int seed = 32'h5300;
  int n_acq = 0;
  int n0;
  int dc = 0;
  int n_rb = 0;
  int r0;
  hcs_link_if u_hcs_link_if ();
  hcs_device u_hcs_device (.*, .link(u_hcs_link_if.device));
  hcs_host #(.HALF_CYC(6), .STROBE_CYC(4)) u_hcs_host (.*, .link(u_hcs_link_if.host));
  hcs_link_properties u_hcs_link_properties (.*, .sclk(u_hcs_link_if.sclk), .sync_n(u_hcs_link_if.sync_n),
    .dout(u_hcs_link_if.dout), .dout_oe(u_hcs_link_if.dout_oe), .busy_n(u_hcs_link_if.busy_n),
    .hold_release(u_hcs_link_if.hold_release));
  // free-running reference clock
  initial
    forever #10 ref_clk_i = ~ref_clk_i;
  // converter stand-in: done after 16 busy cycles, code stored per target
  always @(negedge ref_clk_i)
  begin
    acq_done_i <= acq_start_o && dc == 15;
    dc <= acq_start_o ? dc + 1 : 0;
    n_rb <= n_rb + rb_valid_o;
    if (acq_start_o && dc == 15)
    begin
      n_acq++;
      for (int i = 0; i < 32; i++)
        if (all_t)
          mem[i] = cd;
      if (!all_t)
        mem[tgt] = cd;
    end
  end
  task chk(input string nm, input logic [13:0] e, input logic [13:0] s);
    checked++;
    if (e !== s)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one command, then wait out the acquisition it may start
  task run(input logic [1:0] m, input logic c, input logic o, input logic p, input logic [4:0] ch);
    n0 = n_acq;
    r0 = n_rb;
    cd = 14'($random(seed));
    acq_code_i = cd;
    tgt = o ? 6'h20 : {1'h0, ch};
    all_t = c;
    {cmd_mode_i, cmd_cal_i, cmd_offset_i, par_sel_i, cmd_channel_i} = {m, c, o, p, ch};
    cmd_valid_i = 1'h1;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'h0;
    repeat (40) @(negedge ref_clk_i);
    while (!(cmd_ready_o && !busy_o && !acq_start_o))
      @(negedge ref_clk_i);
    chk("acquires", 14'((p || m == 2'h0 || m == 2'h2) && hold_release_i), 14'(n_acq - n0));
    chk("rb_valid", 14'(!p && m[1]), 14'(n_rb - r0));
    if (p || m == 2'h0 || m == 2'h2)
    begin
      chk("target", 14'(tgt), 14'(acq_channel_o));
      chk("all", 14'(c), 14'(acq_all_o));
    end
    if (!p && m[1])
      chk("readback", mem[ch], rb_data_o);
  endtask
  task summarize;
    $display("errors %0d in %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog, well beyond the expected run length
  initial
  begin
    #1500000;
    err_count++;
    summarize();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    foreach (mem[i])
      mem[i] = 14'h0000;
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    run(2'h0, 1'h0, 1'h0, 1'h0, 5'h1F);
    run(2'h2, 1'h0, 1'h0, 1'h0, 5'h00);
    run(2'h1, 1'h0, 1'h0, 1'h0, 5'h15);
    run(2'h3, 1'h1, 1'h0, 1'h0, 5'h1F);
    run(2'h0, 1'h0, 1'h1, 1'h1, 5'h0A);
    run(2'h0, 1'h1, 1'h0, 1'h0, 5'h03);
    run(2'h3, 1'h0, 1'h0, 1'h0, 5'h0A);
    // acquisition deferred while hold-release is low
    hold_release_i = 1'h0;
    run(2'h0, 1'h0, 1'h0, 1'h0, 5'h07);
    chk("routed", 14'h0001, 14'(route_vin_o));
    hold_release_i = 1'h1;
    repeat (60) @(negedge ref_clk_i);
    chk("deferred", 14'(n0 + 1), 14'(n_acq));
    // short low pulse restores power-on codes
    reset_pulse_i = 1'h1;
    @(negedge ref_clk_i);
    reset_pulse_i = 1'h0;
    repeat (40) @(negedge ref_clk_i);
    foreach (mem[i])
      mem[i] = 14'h0000;
    run(2'h3, 1'h0, 1'h0, 1'h0, 5'h07);
    for (int i = 0; i < 12; i++)
    begin
      r = $random(seed);
      run(r[1:0], r[2] & ~|r[1:0], r[3] & ~|r[1:0] & ~r[2], r[4] & ~|r[1:0], r[9:5]);
    end
    summarize();
  end
endmodule // tb_top
